// ### logic/bms_boot_select.sv
// boot path selection: strap capture, signature path and channel polling
`timescale 1ns/10ps
`default_nettype none
`include "bms_defines.svh"

module bms_boot_select
    import bms_pkg::*;
#(
    parameter int CAN_DOM_CYCLES = `BMS_CAN_DOM_CYCLES,
    parameter int SRST_CYCLES    = `BMS_SRST_CYCLES
)
(
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   reset_input_pin_i,
    input  wire logic                   boot_strap_high_i,
    input  wire logic                   boot_strap_low_i,
    input  wire logic                   uart_receive_line_i,
    input  wire logic                   can_receive_line_i,
    output logic                        flash_rd_req_o,
    output logic [`BMS_ADDR_W-1:0]      flash_rd_addr_o,
    input  wire logic                   flash_rd_ack_i,
    input  wire logic [`BMS_DATA_W-1:0] flash_rd_data_i,
    output logic [1:0]                  boot_strap_o,
    output logic [`BMS_ADDR_W-1:0]      fetch_base_o,
    output logic                        test_flash_fetch_o,
    output logic                        user_flash_data_o,
    output logic                        user_run_o,
    output logic                        soft_reset_o,
    output logic                        polling_o,
    output logic                        uart_boot_o,
    output logic                        can_boot_o,
    output logic                        halt_loop_o,
    output logic                        reserved_mode_o
);

    localparam int NPIN  = 5;
    localparam int CNT_W = $clog2(((CAN_DOM_CYCLES > SRST_CYCLES) ?
                                   CAN_DOM_CYCLES : SRST_CYCLES) + 1);
    localparam logic [NPIN-1:0] PIN_IDLE = 5'h1f;

    // pin order: reset pin, strap high, strap low, uart, can
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_q, s2_q, s3_q;
    logic [NPIN-1:0] filt_q, filt_d;

    assign pin_raw = {reset_input_pin_i, boot_strap_high_i, boot_strap_low_i,
                      uart_receive_line_i, can_receive_line_i};

    // four flops per pin; a level is taken once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NPIN; g++)
        begin : g_sync
            always_comb
            begin
                filt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : filt_q[g];
            end

            always_ff @(posedge clock_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    s1_q[g]   <= (g == NPIN-1) ? 1'b0 : PIN_IDLE[g];
                    s2_q[g]   <= (g == NPIN-1) ? 1'b0 : PIN_IDLE[g];
                    s3_q[g]   <= (g == NPIN-1) ? 1'b0 : PIN_IDLE[g];
                    filt_q[g] <= (g == NPIN-1) ? 1'b0 : PIN_IDLE[g];
                end
                else
                begin
                    s1_q[g]   <= pin_raw[g];
                    s2_q[g]   <= s1_q[g];
                    s3_q[g]   <= s2_q[g];
                    filt_q[g] <= filt_d[g];
                end
            end
        end
    endgenerate

    logic pin_rst_lvl;
    logic uart_lvl;
    logic can_lvl;
    assign pin_rst_lvl = filt_q[4];
    assign uart_lvl    = filt_q[1];
    assign can_lvl     = filt_q[0];

    // the checker runs its reads to the end even if the pin reset drops mid-check;
    // a late done pulse is ignored while the selection waits in hold
    bms_sig_if sig_bus ();

    bms_sig_check u_sig_check (
        .clock_i         (clock_i),
        .rst_n_i         (rst_n_i),
        .sig             (sig_bus.chk),
        .flash_rd_req_o  (flash_rd_req_o),
        .flash_rd_addr_o (flash_rd_addr_o),
        .flash_rd_ack_i  (flash_rd_ack_i),
        .flash_rd_data_i (flash_rd_data_i)
    );

    // output decode shared by the register stage
    function automatic logic [9:0] out_decode(input bms_state_e st);
        logic [9:0] o;
        o = 10'h000;
        // bits: fetch_tf, data_uf, run, srst, poll, uart, can, loop, rsvd, unused
        case (st)
            BMS_ST_USER:     o = 10'h300 >> 1;
            BMS_ST_SIG:      o = 10'h300;
            BMS_ST_SRST:     o = 10'h340;
            BMS_ST_POLL:     o = 10'h320;
            BMS_ST_UART:     o = 10'h310;
            BMS_ST_CAN:      o = 10'h308;
            BMS_ST_LOOP:     o = 10'h304;
            BMS_ST_RESERVED: o = 10'h002;
            default:         o = 10'h000;
        endcase
        return o;
    endfunction

    bms_state_e       st_q, st_d;
    logic [1:0]       strap_q, strap_d;
    logic             rst_prev_q, rst_prev_d;
    logic             uart_prev_q, uart_prev_d;
    logic             en_uart_q, en_uart_d;
    logic             en_can_q, en_can_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             start_q, start_d;
    logic [9:0]       out_q, out_d;
    logic             uart_start;
    logic             can_dom;

    // falling edge of the filtered uart line is a start condition
    assign uart_start = en_uart_q && uart_prev_q && !uart_lvl;
    // a dominant bit is valid after CAN_DOM_CYCLES low samples in a row
    assign can_dom    = en_can_q && !can_lvl &&
                        (cnt_q == CNT_W'(CAN_DOM_CYCLES - 1));

    always_comb
    begin
        st_d        = st_q;
        strap_d     = strap_q;
        rst_prev_d  = pin_rst_lvl;
        uart_prev_d = uart_lvl;
        en_uart_d   = en_uart_q;
        en_can_d    = en_can_q;
        cnt_d       = cnt_q;
        start_d     = 1'b0;
        case (st_q)
            BMS_ST_HOLD:
            begin
                // straps pass the same filter as the pin, so both line up at the rise
                if (pin_rst_lvl && !rst_prev_q)
                begin
                    strap_d = {filt_q[3], filt_q[2]};
                    st_d    = BMS_ST_DECODE;
                end
            end
            BMS_ST_DECODE:
            begin
                // every path starts with both channels allowed; the key may narrow it
                en_uart_d = 1'b1;
                en_can_d  = 1'b1;
                cnt_d     = '0;
                case (strap_q)
                    `BMS_STRAP_USER:   st_d = BMS_ST_USER;
                    `BMS_STRAP_STD:    st_d = BMS_ST_POLL;
                    `BMS_STRAP_SELECT:
                    begin
                        start_d = 1'b1;
                        st_d    = BMS_ST_SIG;
                    end
                    default:           st_d = BMS_ST_RESERVED;
                endcase
            end
            BMS_ST_SIG:
            begin
                if (sig_bus.done && sig_bus.sig_ok)
                begin
                    cnt_d = '0;
                    st_d  = BMS_ST_SRST;
                end
                else if (sig_bus.done)
                begin
                    case (sig_bus.key)
                        `BMS_KEY_STD:  st_d = BMS_ST_POLL;
                        `BMS_KEY_UART:
                        begin
                            en_can_d = 1'b0;
                            st_d     = BMS_ST_POLL;
                        end
                        `BMS_KEY_CAN:
                        begin
                            en_uart_d = 1'b0;
                            st_d      = BMS_ST_POLL;
                        end
                        default:       st_d = BMS_ST_LOOP;
                    endcase
                end
            end
            BMS_ST_SRST:
            begin
                // soft reset lasts SRST_CYCLES clocks, counted up from zero
                if (cnt_q == CNT_W'(SRST_CYCLES - 1))
                begin
                    st_d = BMS_ST_USER;
                end
                else
                begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            BMS_ST_POLL:
            begin
                // an idle unused line never matches; uart wins a tie
                if (uart_start)
                begin
                    st_d = BMS_ST_UART;
                end
                else if (can_dom)
                begin
                    st_d = BMS_ST_CAN;
                end
                else if (en_can_q && !can_lvl)
                begin
                    cnt_d = cnt_q + 1'b1;
                end
                else
                begin
                    cnt_d = '0;
                end
            end
            BMS_ST_USER, BMS_ST_UART, BMS_ST_CAN, BMS_ST_LOOP, BMS_ST_RESERVED:
            begin
                st_d = st_q;
            end
            default:
            begin
                st_d = BMS_ST_HOLD;
            end
        endcase
        // pin reset held low restarts the selection
        if (!pin_rst_lvl)
        begin
            st_d = BMS_ST_HOLD;
        end
        // outcomes follow the next state so they leave a flop together with it
        out_d = out_decode(st_d);
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q        <= BMS_ST_HOLD;
            strap_q     <= `BMS_STRAP_RESERVED;
            rst_prev_q  <= 1'b0;
            uart_prev_q <= 1'b1;
            en_uart_q   <= 1'b0;
            en_can_q    <= 1'b0;
            cnt_q       <= '0;
            start_q     <= 1'b0;
            out_q       <= 10'h000;
        end
        else
        begin
            st_q        <= st_d;
            strap_q     <= strap_d;
            rst_prev_q  <= rst_prev_d;
            uart_prev_q <= uart_prev_d;
            en_uart_q   <= en_uart_d;
            en_can_q    <= en_can_d;
            cnt_q       <= cnt_d;
            start_q     <= start_d;
            out_q       <= out_d;
        end
    end

    assign sig_bus.start = start_q;

    assign boot_strap_o       = strap_q;
    // both flashes share one base; the fetch flag picks which answers code fetches
    assign fetch_base_o       = `BMS_FLASH_BASE;
    assign test_flash_fetch_o = out_q[9];
    assign user_flash_data_o  = out_q[8];
    assign user_run_o         = out_q[7];
    assign soft_reset_o       = out_q[6];
    assign polling_o          = out_q[5];
    assign uart_boot_o        = out_q[4];
    assign can_boot_o         = out_q[3];
    assign halt_loop_o        = out_q[2];
    assign reserved_mode_o    = out_q[1];

endmodule

`default_nettype wire

// ### logic/bms_defines.svh
// constants for the boot mode selection block
`ifndef BMS_DEFINES_SVH
`define BMS_DEFINES_SVH

`define BMS_CLK_FREQ_MHZ     20
`define BMS_DATA_W           16
`define BMS_ADDR_W           24

// strap codes as {high, low}
`define BMS_STRAP_USER       2'h3
`define BMS_STRAP_STD        2'h2
`define BMS_STRAP_SELECT     2'h1
`define BMS_STRAP_RESERVED   2'h0

// code base of both flashes
`define BMS_FLASH_BASE       24'h000000

// reserved flash locations read by the selective path
`define BMS_ADDR_SIG_A       24'h000100
`define BMS_ADDR_SIG_B       24'h000102
`define BMS_ADDR_KEY         24'h000104
`define BMS_SIG_REF          16'h5aa5

// user key codes
`define BMS_KEY_STD          16'h0001
`define BMS_KEY_UART         16'h0002
`define BMS_KEY_CAN          16'h0003

// least low time of a valid dominant bit, and its cycle count
`define BMS_CAN_DOM_TIME_NS  500
`define BMS_CAN_DOM_CYCLES   ((`BMS_CAN_DOM_TIME_NS * `BMS_CLK_FREQ_MHZ + 999) / 1000)

// length of the software reset pulse
`define BMS_SRST_TIME_NS     1000
`define BMS_SRST_CYCLES      ((`BMS_SRST_TIME_NS * `BMS_CLK_FREQ_MHZ + 999) / 1000)

`endif

// ### logic/bms_pkg.sv
// types of the boot mode selection block
package bms_pkg;

    typedef enum logic [3:0] {
        BMS_ST_HOLD     = 4'h0,
        BMS_ST_DECODE   = 4'h1,
        BMS_ST_USER     = 4'h2,
        BMS_ST_SIG      = 4'h3,
        BMS_ST_SRST     = 4'h4,
        BMS_ST_POLL     = 4'h5,
        BMS_ST_UART     = 4'h6,
        BMS_ST_CAN      = 4'h7,
        BMS_ST_LOOP     = 4'h8,
        BMS_ST_RESERVED = 4'h9
    } bms_state_e;

    typedef enum logic [2:0] {
        BMS_CK_IDLE = 3'h0,
        BMS_CK_RD_A = 3'h1,
        BMS_CK_RD_B = 3'h2,
        BMS_CK_CMP  = 3'h3,
        BMS_CK_KEY  = 3'h4,
        BMS_CK_DONE = 3'h5
    } bms_chk_state_e;

endpackage

// ### logic/bms_sig_if.sv
// carrier between the boot selector and the signature checker
`timescale 1ns/10ps
`default_nettype none

interface bms_sig_if;
    logic        start;
    logic        done;
    logic        sig_ok;
    logic [15:0] key;

    modport ctrl (output start, input done, input sig_ok, input key);
    modport chk  (input start, output done, output sig_ok, output key);
endinterface

`default_nettype wire

// ### logic/bms_sig_check.sv
// reads the signature locations, and the key location only when the signature fails, and judges the signature
`timescale 1ns/10ps
`default_nettype none
`include "bms_defines.svh"

module bms_sig_check
    import bms_pkg::*;
(
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    bms_sig_if.chk                      sig,
    output logic                        flash_rd_req_o,
    output logic [`BMS_ADDR_W-1:0]      flash_rd_addr_o,
    input  wire logic                   flash_rd_ack_i,
    input  wire logic [`BMS_DATA_W-1:0] flash_rd_data_i
);

    bms_chk_state_e         st_q, st_d;
    logic [`BMS_DATA_W-1:0] word_a_q, word_a_d;
    logic [`BMS_DATA_W-1:0] sum_q, sum_d;
    logic [`BMS_DATA_W-1:0] key_q, key_d;
    logic                   ok_q, ok_d;

    always_comb
    begin
        st_d     = st_q;
        word_a_d = word_a_q;
        sum_d    = sum_q;
        key_d    = key_q;
        ok_d     = ok_q;
        case (st_q)
            BMS_CK_IDLE:
            begin
                if (sig.start)
                begin
                    ok_d  = 1'b0;
                    key_d = '0;
                    st_d  = BMS_CK_RD_A;
                end
            end
            BMS_CK_RD_A:
            begin
                if (flash_rd_ack_i)
                begin
                    word_a_d = flash_rd_data_i;
                    st_d     = BMS_CK_RD_B;
                end
            end
            BMS_CK_RD_B:
            begin
                if (flash_rd_ack_i)
                begin
                    sum_d = word_a_q + flash_rd_data_i;
                    st_d  = BMS_CK_CMP;
                end
            end
            BMS_CK_CMP:
            begin
                ok_d = (sum_q == `BMS_SIG_REF);
                st_d = (sum_q == `BMS_SIG_REF) ? BMS_CK_DONE : BMS_CK_KEY;
            end
            BMS_CK_KEY:
            begin
                if (flash_rd_ack_i)
                begin
                    key_d = flash_rd_data_i;
                    st_d  = BMS_CK_DONE;
                end
            end
            BMS_CK_DONE:
            begin
                st_d = BMS_CK_IDLE;
            end
            default:
            begin
                st_d = BMS_CK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q     <= BMS_CK_IDLE;
            word_a_q <= '0;
            sum_q    <= '0;
            key_q    <= '0;
            ok_q     <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            word_a_q <= word_a_d;
            sum_q    <= sum_d;
            key_q    <= key_d;
            ok_q     <= ok_d;
        end
    end

    assign flash_rd_req_o  = (st_q == BMS_CK_RD_A) || (st_q == BMS_CK_RD_B)
                             || (st_q == BMS_CK_KEY);
    assign flash_rd_addr_o = (st_q == BMS_CK_RD_B) ? `BMS_ADDR_SIG_B :
                             (st_q == BMS_CK_KEY)  ? `BMS_ADDR_KEY   : `BMS_ADDR_SIG_A;
    assign sig.done        = (st_q == BMS_CK_DONE);
    assign sig.sig_ok      = ok_q;
    assign sig.key         = key_q;

endmodule

`default_nettype wire

// ### dv/bms_boot_select_sva.sv
// assertion checker for the boot mode selection block
`timescale 1ns/10ps
`default_nettype none
`include "bms_defines.svh"

module bms_boot_select_sva
#(
    parameter int CAN_DOM_CYCLES = 10,
    parameter int SRST_CYCLES    = 20
)
(
    input wire logic                   clock_i,
    input wire logic                   rst_n_i,
    input wire logic                   reset_input_pin_i,
    input wire logic                   boot_strap_high_i,
    input wire logic                   boot_strap_low_i,
    input wire logic                   uart_receive_line_i,
    input wire logic                   can_receive_line_i,
    input wire logic                   flash_rd_req_o,
    input wire logic [`BMS_ADDR_W-1:0] flash_rd_addr_o,
    input wire logic                   flash_rd_ack_i,
    input wire logic [`BMS_DATA_W-1:0] flash_rd_data_i,
    input wire logic [1:0]             boot_strap_o,
    input wire logic [`BMS_ADDR_W-1:0] fetch_base_o,
    input wire logic                   test_flash_fetch_o,
    input wire logic                   user_flash_data_o,
    input wire logic                   user_run_o,
    input wire logic                   soft_reset_o,
    input wire logic                   polling_o,
    input wire logic                   uart_boot_o,
    input wire logic                   can_boot_o,
    input wire logic                   halt_loop_o,
    input wire logic                   reserved_mode_o
);
    logic [7:0] srst_q;
    logic [7:0] srst_d;
    logic [7:0] lo_q;
    logic [7:0] lo_d;

    // length of the soft reset pulse and of the present low run on the can line
    always_comb
    begin
        srst_d = soft_reset_o ? srst_q + 8'h01 : 8'h00;
        lo_d   = can_receive_line_i ? 8'h00 : ((lo_q == 8'hff) ? lo_q : lo_q + 8'h01);
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            srst_q <= 8'h00;
            lo_q   <= 8'h00;
        end
        else
        begin
            srst_q <= srst_d;
            lo_q   <= lo_d;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_srst_end;
        (srst_q == SRST_CYCLES) ##[0:1] (user_run_o && !test_flash_fetch_o);
    endsequence

    property p_strap_hold;
        (polling_o || user_run_o || halt_loop_o) && reset_input_pin_i |=> $stable(boot_strap_o);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("captured straps moved");

    property p_user;
        user_run_o && boot_strap_o == `BMS_STRAP_USER |->
            user_flash_data_o && !test_flash_fetch_o && fetch_base_o == `BMS_FLASH_BASE;
    endproperty
    a_user: assert property (p_user) else $error("user mode mapping wrong");

    property p_std;
        polling_o |-> test_flash_fetch_o && user_flash_data_o && fetch_base_o == `BMS_FLASH_BASE;
    endproperty
    a_std: assert property (p_std) else $error("loader mapping wrong");

    property p_srst;
        $fell(soft_reset_o) |-> s_srst_end;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset length or follow-up wrong");

    property p_rd_mode;
        flash_rd_req_o || soft_reset_o |-> boot_strap_o == `BMS_STRAP_SELECT;
    endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("signature path outside selective");

    property p_rd_hold;
        flash_rd_req_o && !flash_rd_ack_i |=> flash_rd_req_o && $stable(flash_rd_addr_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("flash read dropped before ack");

    property p_one;
        $onehot0({user_run_o, polling_o, uart_boot_o, can_boot_o, halt_loop_o, reserved_mode_o});
    endproperty
    a_one: assert property (p_one) else $error("more than one boot outcome");

    property p_uart;
        $rose(uart_boot_o) |-> $past(polling_o) && !polling_o && !can_boot_o;
    endproperty
    a_uart: assert property (p_uart) else $error("uart boot without polling");

    property p_can;
        // the pin filter delays the line by four samples, so look at the run back then
        $rose(can_boot_o) |-> $past(polling_o) && $past(lo_q, 4) >= CAN_DOM_CYCLES
            && !uart_boot_o;
    endproperty
    a_can: assert property (p_can) else $error("can boot without valid dominant bit");

    property p_rsv;
        reserved_mode_o |-> boot_strap_o == `BMS_STRAP_RESERVED && !flash_rd_req_o
            && !test_flash_fetch_o;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved code entered a path");
endmodule

bind bms_boot_select bms_boot_select_sva #(
    .CAN_DOM_CYCLES(CAN_DOM_CYCLES),
    .SRST_CYCLES   (SRST_CYCLES)
) u_sva (
    .clock_i, .rst_n_i, .reset_input_pin_i, .boot_strap_high_i, .boot_strap_low_i,
    .uart_receive_line_i, .can_receive_line_i, .flash_rd_req_o, .flash_rd_addr_o,
    .flash_rd_ack_i, .flash_rd_data_i, .boot_strap_o, .fetch_base_o, .test_flash_fetch_o,
    .user_flash_data_o, .user_run_o, .soft_reset_o, .polling_o, .uart_boot_o,
    .can_boot_o, .halt_loop_o, .reserved_mode_o
);

`default_nettype wire

// ### dv/bms_flash_model.sv
// flash read model holding the signature and key words
`timescale 1ns/10ps
`default_nettype none
`include "bms_defines.svh"

module bms_flash_model
(
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   req_i,
    input  wire logic [`BMS_ADDR_W-1:0] addr_i,
    input  wire logic [1:0]             delay_i,
    input  wire logic [15:0]            sig_a_i,
    input  wire logic [15:0]            sig_b_i,
    input  wire logic [15:0]            key_i,
    output logic                        ack_o,
    output logic [15:0]                 data_o
);
    logic [1:0] wait_q;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_o  <= 1'b0;
            data_o <= 16'h0000;
            wait_q <= 2'h0;
        end
        else if (req_i && !ack_o && wait_q >= delay_i)
        begin
            ack_o  <= 1'b1;
            wait_q <= 2'h0;
            case (addr_i)
                `BMS_ADDR_SIG_A: data_o <= sig_a_i;
                `BMS_ADDR_SIG_B: data_o <= sig_b_i;
                `BMS_ADDR_KEY:   data_o <= key_i;
                default:         data_o <= ~addr_i[15:0];
            endcase
        end
        else
        begin
            // one-cycle ack; data is inverted every cycle outside it, so a stale word shows only on alternate cycles
            ack_o  <= 1'b0;
            data_o <= ~data_o;
            if (req_i && !ack_o)
                wait_q <= wait_q + 2'h1;
        end
    end
endmodule

`default_nettype wire

// ### dv/test_boot_mode_selection.sv
// self-checking bench for the boot mode selection block
`timescale 1ns/10ps
`default_nettype none
`include "bms_defines.svh"

module test_boot_mode_selection;
    localparam int DOM  = 2;
    localparam int SRST = 2;

    logic                   clock_i = 1'b0;
    logic                   rst_n_i = 1'b0;
    logic                   pin     = 1'b0;
    logic                   s_hi    = 1'b0;
    logic                   s_lo    = 1'b0;
    logic                   rx_u    = 1'b1;
    logic                   rx_c    = 1'b1;
    logic [15:0]            sig_a   = 16'h0000;
    logic [15:0]            sig_b   = 16'h0000;
    logic [15:0]            key     = 16'h0000;
    logic [1:0]             delay   = 2'h0;
    logic                   rd_req;
    logic                   rd_ack;
    logic [`BMS_ADDR_W-1:0] rd_addr;
    logic [`BMS_ADDR_W-1:0] base;
    logic [15:0]            rd_data;
    logic [1:0]             strap;
    logic                   tff, ufd, urun, srst, poll, ub, cb, halt, rsv;
    int                     n_errors   = 0;
    int                     n_compared = 0;
    integer                 seed       = 32'h9cf4;

    always #25 clock_i = ~clock_i;

    bms_boot_select #(.CAN_DOM_CYCLES(DOM), .SRST_CYCLES(SRST)) uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reset_input_pin_i(pin),
        .boot_strap_high_i(s_hi), .boot_strap_low_i(s_lo), .uart_receive_line_i(rx_u),
        .can_receive_line_i(rx_c), .flash_rd_req_o(rd_req), .flash_rd_addr_o(rd_addr),
        .flash_rd_ack_i(rd_ack), .flash_rd_data_i(rd_data), .boot_strap_o(strap),
        .fetch_base_o(base), .test_flash_fetch_o(tff), .user_flash_data_o(ufd),
        .user_run_o(urun), .soft_reset_o(srst), .polling_o(poll), .uart_boot_o(ub),
        .can_boot_o(cb), .halt_loop_o(halt), .reserved_mode_o(rsv)
    );

    bms_flash_model u_flash (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(rd_req), .addr_i(rd_addr),
        .delay_i(delay), .sig_a_i(sig_a), .sig_b_i(sig_b), .key_i(key),
        .ack_o(rd_ack), .data_o(rd_data)
    );

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check4(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // outcome as {user_run, polling, halt, reserved}
    function automatic logic [3:0] exp_status(input logic [1:0] st, input logic ok,
                                              input logic [15:0] k);
        case (st)
            `BMS_STRAP_USER:   return 4'h8;
            `BMS_STRAP_STD:    return 4'h4;
            `BMS_STRAP_SELECT: return ok ? 4'h8 : ((k >= 16'h0001 && k <= `BMS_KEY_CAN) ? 4'h4 : 4'h2);
            default:           return 4'h1;
        endcase
    endfunction

    // channel taken as {uart, can}; ch 0 uart only, 1 can only, 2 both at once
    function automatic logic [1:0] exp_chan(input logic [1:0] st, input logic [15:0] k,
                                            input int ch);
        logic au;
        logic ac;
        au = st == `BMS_STRAP_STD || k == `BMS_KEY_STD || k == `BMS_KEY_UART;
        ac = st == `BMS_STRAP_STD || k == `BMS_KEY_STD || k == `BMS_KEY_CAN;
        if (au && ch != 1)
            return 2'h2;
        if (ac && ch != 0)
            return 2'h1;
        return 2'h0;
    endfunction

    task automatic run_boot(input logic [1:0] st, input logic ok, input logic [15:0] k,
                            input int ch);
        logic [3:0]  exp;
        logic [15:0] a;
        int          n;
        int          n_sr;
        exp = exp_status(st, ok, k);
        a = 16'($random(seed));
        @(posedge clock_i);
        pin   <= 1'b0;
        s_hi  <= st[1];
        s_lo  <= st[0];
        sig_a <= a;
        sig_b <= ok ? `BMS_SIG_REF - a : ~a;
        key   <= k;
        delay <= 2'($random(seed));
        repeat (8) @(posedge clock_i);
        pin <= 1'b1;
        repeat (8) @(posedge clock_i);
        s_hi <= ~st[1];
        s_lo <= ~st[0];
        n = 0;
        n_sr = 0;
        while (!(urun || poll || halt || rsv) && n < 200)
        begin
            @(negedge clock_i);
            n++;
            n_sr += srst;
        end
        if (n >= 200)
        begin
            n_errors++;
            $display("Error at %0t: no boot decision", $time);
            return;
        end
        repeat (3) @(negedge clock_i);
        check4({urun, poll, halt, rsv}, exp);
        check4({2'h0, strap}, {2'h0, st});
        check4(4'(n_sr), (st == `BMS_STRAP_SELECT && ok) ? 4'(SRST) : 4'h0);
        if (exp == 4'h8 || exp == 4'h4)
            check4({tff, ufd, 2'h0}, {exp == 4'h4, 1'b1, 2'h0});
        if (exp == 4'h4)
        begin
            @(posedge clock_i);
            rx_u <= (ch == 1);
            rx_c <= (ch == 0);
            repeat (8) @(posedge clock_i);
            rx_u <= 1'b1;
            rx_c <= 1'b1;
            repeat (4) @(negedge clock_i);
            check4({2'h0, ub, cb}, {2'h0, exp_chan(st, k, ch)});
        end
    endtask

    initial
    begin
        logic [1:0]  st;
        logic [15:0] k;
        logic        ok;
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            st = (i < 4) ? i[1:0] : ((i < 16) ? `BMS_STRAP_SELECT : 2'($random(seed)));
            k  = (i % 4 == 3) ? (16'($random(seed)) | 16'h0004) : 16'(i % 4 + 1);
            ok = i < 4 || (i >= 12 && i < 16) || (i >= 16 && seed[0]);
            run_boot(st, ok, k, (i / 4 + i) % 3);
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
